// File: verilog/dclh_port.sv
// Ring link port: transmitter, receiver, watchdogs and the two-pass probe handshake.
// Assumes the neighbour drives its own clock alongside its data and idles the lines low.
module dclh_port
  import dclh_pkg::*;
#(
  parameter int WD_PING_LIMIT  = WD_PING_CYC,
  parameter int WD_FRAME_LIMIT = WD_FRAME_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        is_leader,
  input  wire logic        hs_start,
  input  wire logic [15:0] retry_cycles,
  input  wire logic [3:0]  probe_need,
  input  wire logic        ping_irq_en,
  input  wire logic        wd_ping_en,
  input  wire logic        wd_frame_en,
  input  wire logic        tx_two_lanes,
  input  wire logic [1:0]  tx_words,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  input  wire logic [3:0]  tx_tag,
  input  wire logic [63:0] tx_data,
  output dclh_lines_t      serial_transmitter,
  input  wire logic        rx_two_lanes,
  input  wire logic [1:0]  rx_words,
  input  wire dclh_skew_t  rx_skew,
  input  wire dclh_lines_t serial_receiver,
  output logic             rx_valid,
  output dclh_frame_t      rx_frame,
  output logic             crc_err,
  output logic             first_interrupt_line,
  output logic             ping_wd_expired,
  output logic             frame_wd_expired,
  output logic             path_ok
);

  typedef enum logic [2:0] {
    HS_IDLE, HS_SEND0, HS_WAIT0, HS_SEND1, HS_WAIT1, HS_ACK, HS_DONE
  } dclh_hs_t;

  dclh_hs_t         hs_q;
  logic             tx_busy_q;
  logic             tx_lanes_q;
  logic [1:0]       ph_q;
  logic [4:0]       flush_q;
  logic [6:0]       tx_left_q;
  logic [SR_W-1:0]  tx_sr_q;
  dclh_lines_t      rx_l;
  logic             rx_clk_prev_q;
  logic             rx_busy_q;
  logic             rx_done_q;
  logic [6:0]       rx_cnt_q;
  logic [SR_W-1:0]  rx_sr_q;
  logic [15:0]      tmr_q;
  logic [3:0]       probes_q;
  logic [31:0]      wd_ping_q;
  logic [31:0]      wd_frame_q;

  // ****************************************************************
  // Transmitter
  // ****************************************************************
  logic        hs_req;
  logic        tx_load;
  dclh_frame_t tx_f;
  logic        tx_flush;
  logic [72:0] tx_tail;

  always_comb begin
    hs_req   = (hs_q == HS_SEND0 || hs_q == HS_SEND1 || hs_q == HS_ACK) && !tx_busy_q;
    tx_ready = (hs_q == HS_DONE) && !tx_busy_q;
    tx_load  = hs_req || (tx_valid && tx_ready);
    tx_f     = '0;
    tx_f.ftype = hs_req ? FT_PING : FT_DATA;
    tx_f.words = hs_req ? 2'h0 : tx_words;
    tx_f.data  = hs_req ? '0 : tx_data;
    if (!hs_req) begin
      tx_f.tag = tx_tag;
    end else if (hs_q == HS_ACK || (hs_q == HS_SEND1 && is_leader)) begin
      tx_f.tag = TAG_ACK;
    end else begin
      tx_f.tag = TAG_PATH;
    end
    tx_flush = hs_req && (hs_q == (is_leader ? HS_SEND0 : HS_SEND1));
    tx_tail  = {tx_f.data, dclh_crc8(dclh_body(tx_f), tx_f.words), 1'b0} << {~tx_f.words, 4'h0};
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_busy_q  <= 1'b0;
      tx_lanes_q <= 1'b0;
      ph_q       <= '0;
      flush_q    <= '0;
      tx_left_q  <= '0;
      tx_sr_q    <= '0;
    end else if (tx_load) begin
      tx_busy_q  <= 1'b1;
      tx_lanes_q <= tx_two_lanes;
      ph_q       <= '0;
      flush_q    <= tx_flush ? FLUSH_EDGES : 5'h00;
      tx_left_q  <= dclh_frame_bits(tx_f.words);
      tx_sr_q    <= {1'b1, tx_f.ftype, tx_f.tag, tx_tail};
    end else if (tx_busy_q) begin
      ph_q <= ph_q + 2'h1;
      if (ph_q == PH_LAUNCH && flush_q != 5'h00) begin
        flush_q <= flush_q - 5'h01;
      end else if (ph_q == PH_LAUNCH) begin
        tx_sr_q   <= tx_lanes_q ? {tx_sr_q[SR_W-3:0], 2'b00} : {tx_sr_q[SR_W-2:0], 1'b0};
        tx_left_q <= tx_left_q - (tx_lanes_q ? 7'h02 : 7'h01);
      end
      if (ph_q == PH_LAST && flush_q == 5'h00 && tx_left_q == 7'h00) begin
        tx_busy_q <= 1'b0;
      end
    end
  end

  // Data moves mid half-period so either clock edge finds it settled
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      serial_transmitter <= '0;
    end else if (tx_busy_q && ph_q == PH_LAUNCH) begin
      serial_transmitter.d0 <= (flush_q == 5'h00) && tx_sr_q[SR_W-1];
      serial_transmitter.d1 <= (flush_q == 5'h00) && tx_lanes_q && tx_sr_q[SR_W-2];
    end else if (tx_busy_q && ph_q == PH_LAST) begin
      serial_transmitter.clk <= ~serial_transmitter.clk;
    end
  end

  // ****************************************************************
  // Receiver
  // ****************************************************************
  dclh_rx_front u_front (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pins    (serial_receiver),
    .skew    (rx_skew),
    .lines   (rx_l)
  );

  logic        rx_edge;
  logic [6:0]  rx_cnt_d;
  dclh_frame_t rx_f;
  logic        rx_crc_ok;
  logic        rx_ok;
  logic        got_path;
  logic        got_ack;

  always_comb begin
    rx_edge   = rx_l.clk ^ rx_clk_prev_q;
    rx_cnt_d  = (rx_busy_q ? rx_cnt_q : 7'h00) + (rx_two_lanes ? 7'h02 : 7'h01);
    rx_f.words = rx_words;
    rx_f.ftype = rx_sr_q[7'h1D + {1'b0, rx_words, 4'h0} +: 4];
    rx_f.tag   = rx_sr_q[7'h19 + {1'b0, rx_words, 4'h0} +: 4];
    rx_f.data  = rx_sr_q[72:9] & ({64{1'b1}} >> {~rx_words, 4'h0});
    rx_crc_ok = dclh_crc8(dclh_body(rx_f), rx_words) == rx_sr_q[8:1];
    rx_ok     = rx_done_q && rx_crc_ok;
    got_path  = rx_ok && rx_f.ftype == FT_PING && rx_f.tag == TAG_PATH;
    got_ack   = rx_ok && rx_f.ftype == FT_PING && rx_f.tag == TAG_ACK;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_clk_prev_q <= 1'b0;
      rx_busy_q     <= 1'b0;
      rx_done_q     <= 1'b0;
      rx_cnt_q      <= '0;
      rx_sr_q       <= '0;
    end else begin
      rx_clk_prev_q <= rx_l.clk;
      rx_done_q     <= 1'b0;
      if (rx_edge && (rx_busy_q || rx_l.d0)) begin
        rx_cnt_q <= rx_cnt_d;
        rx_busy_q <= rx_cnt_d < dclh_frame_bits(rx_words);
        rx_done_q <= rx_cnt_d >= dclh_frame_bits(rx_words);
        if (rx_two_lanes) begin
          rx_sr_q <= {rx_busy_q ? rx_sr_q[SR_W-3:0] : 80'h0, rx_l.d0, rx_l.d1};
        end else begin
          rx_sr_q <= {rx_busy_q ? rx_sr_q[SR_W-2:0] : 81'h0, rx_l.d0};
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_valid             <= 1'b0;
      rx_frame             <= '0;
      crc_err              <= 1'b0;
      first_interrupt_line <= 1'b0;
    end else begin
      rx_valid             <= rx_ok && rx_f.ftype == FT_DATA && hs_q == HS_DONE;
      crc_err              <= rx_done_q && !rx_crc_ok;
      first_interrupt_line <= ping_irq_en && rx_ok && rx_f.ftype == FT_PING;
      if (rx_ok) begin
        rx_frame <= rx_f;
      end
    end
  end

  // ****************************************************************
  // Watchdogs
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst || !wd_ping_en || got_path || got_ack) begin
      wd_ping_q <= '0;
    end else if (wd_ping_q != 32'(WD_PING_LIMIT)) begin
      wd_ping_q <= wd_ping_q + 32'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || !wd_frame_en || rx_done_q) begin
      wd_frame_q <= '0;
    end else if (wd_frame_q != 32'(WD_FRAME_LIMIT)) begin
      wd_frame_q <= wd_frame_q + 32'h1;
    end
  end

  always_comb begin
    ping_wd_expired  = wd_ping_q == 32'(WD_PING_LIMIT);
    frame_wd_expired = wd_frame_q == 32'(WD_FRAME_LIMIT);
  end

  // ****************************************************************
  // Handshake
  // ****************************************************************
  logic timeout;
  logic path_hit;

  always_comb begin
    timeout  = tmr_q == retry_cycles && (hs_q == HS_WAIT1 || (is_leader && hs_q == HS_WAIT0));
    path_hit = got_path && (!is_leader || probes_q + 4'h1 >= probe_need);
    path_ok  = hs_q == HS_DONE;
  end

  // Probe count lets a star leader hear every follower before moving on
  always_ff @(posedge sys_clk) begin
    if (rst || hs_q != HS_WAIT0) begin
      probes_q <= '0;
    end else if (got_path) begin
      probes_q <= probes_q + 4'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || (hs_q != HS_WAIT0 && hs_q != HS_WAIT1) || timeout) begin
      tmr_q <= '0;
    end else begin
      tmr_q <= tmr_q + 16'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hs_q <= HS_IDLE;
    end else begin
      case (hs_q)
        HS_IDLE:  if (hs_start) hs_q <= is_leader ? HS_SEND0 : HS_WAIT0;
        HS_SEND0: if (hs_req) hs_q <= HS_WAIT0;
        HS_WAIT0: begin
          if (path_hit) begin
            hs_q <= HS_SEND1;
          end else if (timeout) begin
            hs_q <= HS_SEND0;
          end
        end
        HS_SEND1: if (hs_req) hs_q <= HS_WAIT1;
        HS_WAIT1: begin
          if (got_ack) begin
            hs_q <= is_leader ? HS_DONE : HS_ACK;
          end else if (timeout) begin
            hs_q <= HS_SEND1;
          end
        end
        HS_ACK:   if (hs_req) hs_q <= HS_DONE;
        HS_DONE:  hs_q <= HS_DONE;
        default:  hs_q <= HS_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  tx_clk_phase_a: assert property ($changed(serial_transmitter.clk) |-> $past(ph_q) == PH_LAST)
    else $error("transmit clock toggled off phase");
  tx_data_phase_a: assert property ($changed(serial_transmitter.d0) |-> $past(ph_q) == PH_LAUNCH)
    else $error("transmit data moved near a clock edge");
  leader_pass_one_a: assert property (hs_q == HS_WAIT0 && is_leader && path_hit |=> hs_q == HS_SEND1)
    else $error("leader missed returning path probe");
  follower_wait_a: assert property (hs_q == HS_WAIT0 && !is_leader && !got_path |=> hs_q == HS_WAIT0)
    else $error("follower left pass one without probe");
  leader_finish_a: assert property (hs_q == HS_WAIT1 && is_leader && got_ack |=> path_ok)
    else $error("leader did not finish on acknowledge");
  follower_fwd_a: assert property (hs_q == HS_WAIT1 && !is_leader && got_ack |=> hs_q == HS_ACK ##[1:300] tx_busy_q && tx_sr_q[SR_W-6 -: 4] == TAG_ACK)
    else $error("follower did not forward acknowledge");
  retry_restart_a: assert property (timeout && !path_hit && !got_ack |=> tmr_q == 16'h0 && (hs_q == HS_SEND0 || hs_q == HS_SEND1))
    else $error("retry did not restart the wait");
  data_after_hs_a: assert property (rx_valid |-> $past(hs_q) == HS_DONE && $past(rx_crc_ok))
    else $error("data frame accepted before handshake");
  probe_irq_a: assert property (first_interrupt_line |-> $past(rx_done_q && rx_f.ftype == FT_PING && ping_irq_en))
    else $error("probe interrupt without probe");
  crc_flag_a: assert property (crc_err |-> $past(rx_done_q) && !$past(rx_crc_ok))
    else $error("crc error without bad frame");
  frame_wd_a: assert property (wd_frame_en && !rx_done_q && wd_frame_q == 32'(WD_FRAME_LIMIT - 1) |=> frame_wd_expired)
    else $error("frame watchdog did not expire");

endmodule : dclh_port

// File: verilog/dclh_pkg.sv
// Constants, carrier types and the frame check function of the ring link port.
// Assumes a single 25 MHz system clock and a synchronous active-high reset.
//
// Summary of operation
// - Each port uses one clock line and up to two data lines, the second lane doubling the rate.
// - The transmitter changes data for both edges of its forwarded clock; the receiver samples on both.
// - Transmitter and receiver are set up and run independently so both directions work at once.
// - Frames have a programmable data length and carry a hardware generated and checked CRC.
// - The receiver has a probe watchdog and a frame watchdog that flag a broken line.
// - Each receive line has its own adjustable delay to cancel lane-to-lane skew.
// - The receiver takes frames from the previous device and the transmitter feeds the next.
// - During the handshake frames are probe frames and a received probe raises the first interrupt.
// - One device leads the handshake and every other device follows with the same setup.
// - Leader pass one sends flush and a path probe, then retries until a path probe returns.
// - A follower in pass one waits until a valid path probe arrives, then moves to pass two.
// - Leader pass two sends an acknowledge probe and finishes when one returns, else retries.
// - A follower in pass two sends flush and a path probe and forwards an acknowledge on receipt.
// - The handshake is started once both ports are set up and data waits until it completes.
// - After the handshake a follower treats the path as good and accepts data frames.
// - In a star the leader moves on only after probes from every follower have arrived.
// ****************************************************************
// Package
// ****************************************************************
package dclh_pkg;

  localparam int          CLK_NS        = 40;
  localparam int          LINK_HALF_NS  = 160;
  localparam int          TX_HALF_CYC   = LINK_HALF_NS / CLK_NS;
  localparam logic [1:0]  PH_LAUNCH     = 2'(TX_HALF_CYC / 4);
  localparam logic [1:0]  PH_LAST       = 2'(TX_HALF_CYC - 1);
  localparam logic [4:0]  FLUSH_EDGES   = 5'h10;
  localparam int          WD_PING_US    = 1000;
  localparam int          WD_FRAME_US   = 100;
  localparam int          WD_PING_CYC   = (WD_PING_US * 1000) / CLK_NS;
  localparam int          WD_FRAME_CYC  = (WD_FRAME_US * 1000) / CLK_NS;
  localparam logic [3:0]  FT_PING       = 4'h1;
  localparam logic [3:0]  FT_DATA       = 4'h2;
  localparam logic [3:0]  TAG_PATH      = 4'h0;
  localparam logic [3:0]  TAG_ACK       = 4'h1;
  localparam logic [7:0]  CRC_INIT      = 8'hFF;
  localparam logic [7:0]  CRC_POLY      = 8'h07;
  localparam logic [6:0]  FRAME_FIXED   = 7'h12;
  localparam int          SR_W          = 82;

  typedef struct packed {
    logic clk;
    logic d0;
    logic d1;
  } dclh_lines_t;

  typedef struct packed {
    logic [1:0] clk;
    logic [1:0] d0;
    logic [1:0] d1;
  } dclh_skew_t;

  typedef struct packed {
    logic [3:0]  ftype;
    logic [3:0]  tag;
    logic [1:0]  words;
    logic [63:0] data;
  } dclh_frame_t;

  // Bits on the wire: start, type, tag, payload, crc, pad
  // Zero extend the word count first so four words do not wrap to none
  function automatic logic [6:0] dclh_frame_bits(input logic [1:0] words);
    return FRAME_FIXED + 7'h10 + {1'b0, words, 4'h0};
  endfunction : dclh_frame_bits

  // Left aligns the used payload words under type and tag
  function automatic logic [71:0] dclh_body(input dclh_frame_t f);
    logic [63:0] p;
    p = f.data << {~f.words, 4'h0};
    return {f.ftype, f.tag, p};
  endfunction : dclh_body

  function automatic logic [7:0] dclh_crc8(input logic [71:0] body, input logic [1:0] words);
    logic [7:0] c;
    logic       fb;
    logic [6:0] nb;
    c  = CRC_INIT;
    nb = 7'h18 + {1'b0, words, 4'h0};
    for (int i = 0; i < 72; i++) begin
      if (i < int'(nb)) begin
        fb = c[7] ^ body[71-i];
        c  = {c[6:0], 1'b0};
        if (fb) begin
          c = c ^ CRC_POLY;
        end
      end
    end
    return c;
  endfunction : dclh_crc8

endpackage : dclh_pkg

// File: verilog/dclh_rx_front.sv
// Receive pin front end: two-stage synchronisers and per-line skew delay.
// Assumes the three receive lines are asynchronous to sys_clk.
module dclh_rx_front
  import dclh_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire dclh_lines_t pins,
  input  wire dclh_skew_t  skew,
  output dclh_lines_t      lines
);

  // ****************************************************************
  // Synchronisers
  // ****************************************************************
  dclh_lines_t meta_q;
  dclh_lines_t sync_q;
  logic [2:0]  tap_q [0:2];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pins;
      sync_q <= meta_q;
    end
  end

  // ****************************************************************
  // Skew delay, whole system clocks per step
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tap_q[0] <= '0;
      tap_q[1] <= '0;
      tap_q[2] <= '0;
    end else begin
      tap_q[0] <= {tap_q[0][1:0], sync_q.clk};
      tap_q[1] <= {tap_q[1][1:0], sync_q.d0};
      tap_q[2] <= {tap_q[2][1:0], sync_q.d1};
    end
  end

  function automatic logic pick(input logic now, input logic [2:0] taps, input logic [1:0] sel);
    return (sel == 2'h0) ? now : taps[sel - 2'h1];
  endfunction : pick

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lines <= '0;
    end else begin
      lines.clk <= pick(sync_q.clk, tap_q[0], skew.clk);
      lines.d0  <= pick(sync_q.d0, tap_q[1], skew.d0);
      lines.d1  <= pick(sync_q.d1, tap_q[2], skew.d1);
    end
  end

endmodule : dclh_rx_front

// File: bench/dclh_partner.sv
// Neighbour in the ring: sends frames into the port and decodes the frames it sends.
// Assumes the wire format of dclh_pkg and a link clock of 320 ns period.
// ********
// Neighbour
// ********
module dclh_partner
  import dclh_pkg::*;
(
  input  wire dclh_lines_t tx_lines,
  input  wire logic        two_lanes,
  input  wire logic [1:0]  words,
  output dclh_lines_t      rx_lines
);
  timeunit 1ns;
  timeprecision 1ps;
  int          n_rx;
  int          last_pre;
  int          pre;
  int          nb;
  bit          busy;
  bit          armed;
  bit          q[$];
  logic [89:0] v;
  logic [3:0]  r_type;
  logic [3:0]  r_tag;
  logic [63:0] r_data;
  logic        r_crc_ok;

  function automatic logic [7:0] crc_of(input bit b[$], input int n);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 1; i <= n; i++) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction : crc_of

  initial begin
    rx_lines = '0;
  end

  // Clock stands still between frames and the lines idle low
  task automatic edge_out(input logic a, input logic b);
    rx_lines.d0 = a;
    rx_lines.d1 = b;
    #80;
    rx_lines.clk = ~rx_lines.clk;
    #80;
  endtask : edge_out

  task automatic send(input logic [3:0] ft, input logic [3:0] tag, input logic [1:0] nw,
                      input logic [63:0] data, input bit two, input bit bad);
    bit         b[$];
    logic [7:0] h;
    logic       a;
    int         n;
    n = 8 + 16 * (int'(nw) + 1);
    h = {ft, tag};
    b.push_back(1'b1);
    for (int i = 7; i >= 0; i--) begin
      b.push_back(h[i]);
    end
    for (int i = n - 9; i >= 0; i--) begin
      b.push_back(data[i]);
    end
    h = crc_of(b, n) ^ {8{bad}};
    for (int i = 7; i >= 0; i--) begin
      b.push_back(h[i]);
    end
    b.push_back(1'b0);
    // Odd start offset keeps the link edges off the system clock edges
    #13;
    repeat (16) edge_out(1'b0, 1'b0);
    while (b.size() > 0) begin
      a = b.pop_front();
      edge_out(a, two ? b.pop_front() : 1'b0);
    end
    if (rx_lines.clk) begin
      edge_out(1'b0, 1'b0);
    end
  endtask : send

  // Frame length follows the configured lanes and words
  always @(tx_lines.clk) begin
    if (!armed) begin
      armed = 1'b1;
    end else if (!busy && tx_lines.d0 !== 1'b1) begin
      pre++;
    end else begin
      busy = 1'b1;
      q.push_back(tx_lines.d0);
      if (two_lanes) begin
        q.push_back(tx_lines.d1);
      end
      nb = 8 + 16 * (int'(words) + 1);
      if (q.size() >= nb + 10) begin
        v = '0;
        foreach (q[i]) begin
          v = {v[88:0], q[i]};
        end
        r_type = v[nb + 8 -: 4];
        r_tag = v[nb + 4 -: 4];
        r_data = 64'((v >> 9) & ((90'h1 << (nb - 8)) - 90'h1));
        r_crc_ok = (v[8:1] == crc_of(q, nb)) && !v[0];
        q.delete();
        busy = 1'b0;
        last_pre = pre;
        pre = 0;
        n_rx++;
      end
    end
  end
endmodule : dclh_partner

// File: bench/dclh_port_tb.sv
// Bench: the port as leader, then as follower, against the neighbour model.
// Assumes dclh_pkg wire format; watchdog limits are cut to 200 cycles.
module dclh_port_tb
  import dclh_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, rst, is_leader, hs_start, ping_irq_en, wd_ping_en, wd_frame_en;
  logic        tx_two_lanes, tx_valid, tx_ready, rx_two_lanes, rx_valid, crc_err, path_ok;
  logic        first_interrupt_line, ping_wd_expired, frame_wd_expired, p_two;
  logic [15:0] retry_cycles;
  logic [3:0]  probe_need, tx_tag;
  logic [1:0]  tx_words, rx_words, p_words;
  logic [63:0] tx_data;
  dclh_lines_t serial_transmitter, serial_receiver;
  dclh_skew_t  rx_skew;
  dclh_frame_t rx_frame;
  int          fail_count, n_checks, n_irq, n_crc, n_rxv, cyc;

  dclh_port #(.WD_PING_LIMIT(200), .WD_FRAME_LIMIT(200)) i_dclh_port (
    .sys_clk(sys_clk), .rst(rst), .is_leader(is_leader), .hs_start(hs_start),
    .retry_cycles(retry_cycles), .probe_need(probe_need), .ping_irq_en(ping_irq_en),
    .wd_ping_en(wd_ping_en), .wd_frame_en(wd_frame_en), .tx_two_lanes(tx_two_lanes),
    .tx_words(tx_words), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_tag(tx_tag),
    .tx_data(tx_data), .serial_transmitter(serial_transmitter), .rx_two_lanes(rx_two_lanes),
    .rx_words(rx_words), .rx_skew(rx_skew), .serial_receiver(serial_receiver),
    .rx_valid(rx_valid), .rx_frame(rx_frame), .crc_err(crc_err),
    .first_interrupt_line(first_interrupt_line), .ping_wd_expired(ping_wd_expired),
    .frame_wd_expired(frame_wd_expired), .path_ok(path_ok));
  dclh_partner i_dclh_partner (.tx_lines(serial_transmitter), .two_lanes(p_two),
    .words(p_words), .rx_lines(serial_receiver));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // ********
  // Pulse counters and hang guard
  // ********
  always @(posedge sys_clk) begin
    cyc++;
    n_irq += int'(first_interrupt_line === 1'b1);
    n_crc += int'(crc_err === 1'b1);
    n_rxv += int'(rx_valid === 1'b1);
    if (cyc == 20000) begin
      fail_count++;
      $display("unexpected cycle count expected below 20000 seen 20000");
      results();
    end
  end

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic wait_cnt(ref int c, input int n, input string what);
    for (int i = 0; i < 400 && c < n; i++) begin
      @(posedge sys_clk);
    end
    chk(what, 64'(n), 64'(c));
  endtask : wait_cnt

  task automatic expect_frame(input int n, input logic [3:0] ft, input logic [3:0] tag,
                              input int pre);
    for (int i = 0; i < 2000 && i_dclh_partner.n_rx < n; i++) begin
      @(posedge sys_clk);
    end
    chk("frame count", 64'(n), 64'(i_dclh_partner.n_rx));
    chk("frame type", 64'(ft), 64'(i_dclh_partner.r_type));
    chk("frame tag", 64'(tag), 64'(i_dclh_partner.r_tag));
    chk("frame crc", 64'h1, 64'(i_dclh_partner.r_crc_ok));
    if (pre >= 0) begin
      chk("flush edges", 64'(pre), 64'(i_dclh_partner.last_pre));
    end
  endtask : expect_frame

  task automatic start_hs(input logic lead, input logic [3:0] need, input logic [15:0] rc);
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("tx pins in reset", 64'h0, 64'(serial_transmitter));
    chk("path_ok in reset", 64'h0, 64'(path_ok));
    @(posedge sys_clk);
    rst <= 1'b0;
    is_leader <= lead;
    probe_need <= need;
    retry_cycles <= rc;
    @(posedge sys_clk);
    hs_start <= 1'b1;
    @(posedge sys_clk);
    hs_start <= 1'b0;
  endtask : start_hs

  task automatic leader_run();
    // Wait long enough for both partner probes to land inside one pass one window
    start_hs(1'b1, 4'h2, 16'h2BC);
    expect_frame(1, FT_PING, TAG_PATH, 16);
    repeat (550) @(posedge sys_clk);
    chk("early retry", 64'h1, 64'(i_dclh_partner.n_rx));
    expect_frame(2, FT_PING, TAG_PATH, 16);
    i_dclh_partner.send(FT_PING, TAG_PATH, 2'h0, 64'h0, 1'b0, 1'b0);
    wait_cnt(n_irq, 1, "probe interrupt");
    i_dclh_partner.send(FT_PING, TAG_PATH, 2'h0, 64'h0, 1'b0, 1'b0);
    chk("early pass two", 64'h2, 64'(i_dclh_partner.n_rx));
    expect_frame(3, FT_PING, TAG_ACK, 0);
    chk("tx_ready early", 64'h0, 64'(tx_ready));
    i_dclh_partner.send(FT_PING, TAG_ACK, 2'h0, 64'h0, 1'b0, 1'b1);
    wait_cnt(n_crc, 1, "crc error");
    chk("path_ok after bad", 64'h0, 64'(path_ok));
    expect_frame(4, FT_PING, TAG_ACK, 0);
    i_dclh_partner.send(FT_PING, TAG_ACK, 2'h0, 64'h0, 1'b0, 1'b0);
    for (int i = 0; i < 100 && tx_ready !== 1'b1; i++) begin
      @(posedge sys_clk);
    end
    chk("path_ok", 64'h1, 64'(path_ok));
    p_two <= 1'b1;
    p_words <= 2'h1;
    tx_two_lanes <= 1'b1;
    tx_words <= 2'h1;
    tx_tag <= 4'h5;
    tx_data <= 64'h1234_ABCD;
    tx_valid <= 1'b1;
    @(posedge sys_clk);
    tx_valid <= 1'b0;
    i_dclh_partner.send(FT_DATA, 4'hA, 2'h0, 64'hBEEF, 1'b0, 1'b0);
    wait_cnt(n_rxv, 1, "data in");
    chk("rx data", 64'hBEEF, 64'(rx_frame.data[15:0]));
    expect_frame(5, FT_DATA, 4'h5, -1);
    chk("data out", 64'h1234_ABCD, i_dclh_partner.r_data);
  endtask : leader_run

  task automatic follower_run();
    int b_rx;
    int b_irq;
    int b_rxv;
    b_rx = i_dclh_partner.n_rx;
    b_irq = n_irq;
    b_rxv = n_rxv;
    p_two <= 1'b0;
    p_words <= 2'h0;
    tx_two_lanes <= 1'b0;
    tx_words <= 2'h0;
    wd_ping_en <= 1'b1;
    wd_frame_en <= 1'b1;
    start_hs(1'b0, 4'h1, 16'h1F4);
    // Reset drops a link clock left high by the two lane frame; not a flush edge
    i_dclh_partner.pre = 0;
    i_dclh_partner.send(FT_DATA, 4'h3, 2'h0, 64'h77, 1'b0, 1'b0);
    repeat (250) @(posedge sys_clk);
    chk("data before path", 64'(b_rxv), 64'(n_rxv));
    chk("ping watchdog", 64'h1, 64'(ping_wd_expired));
    chk("frame watchdog", 64'h1, 64'(frame_wd_expired));
    i_dclh_partner.send(FT_PING, TAG_ACK, 2'h0, 64'h0, 1'b0, 1'b0);
    wait_cnt(n_irq, b_irq + 1, "probe interrupt");
    repeat (100) @(posedge sys_clk);
    chk("ping watchdog clear", 64'h0, 64'(ping_wd_expired));
    chk("follower silent", 64'(b_rx), 64'(i_dclh_partner.n_rx));
    i_dclh_partner.send(FT_PING, TAG_PATH, 2'h0, 64'h0, 1'b0, 1'b0);
    expect_frame(b_rx + 1, FT_PING, TAG_PATH, 16);
    expect_frame(b_rx + 2, FT_PING, TAG_PATH, 16);
    rx_skew <= {2'h2, 2'h1, 2'h3};
    i_dclh_partner.send(FT_PING, TAG_ACK, 2'h0, 64'h0, 1'b0, 1'b0);
    expect_frame(b_rx + 3, FT_PING, TAG_ACK, -1);
    chk("path_ok", 64'h1, 64'(path_ok));
    rx_two_lanes <= 1'b1;
    rx_words <= 2'h2;
    i_dclh_partner.send(FT_DATA, 4'hC, 2'h2, 64'h1111_2222_3333, 1'b1, 1'b0);
    wait_cnt(n_rxv, b_rxv + 1, "data in");
    chk("rx data", 64'h1111_2222_3333, 64'(rx_frame.data[47:0]));
    repeat (250) @(posedge sys_clk);
    chk("frame watchdog", 64'h1, 64'(frame_wd_expired));
    wd_frame_en <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("frame watchdog off", 64'h0, 64'(frame_wd_expired));
  endtask : follower_run

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  initial begin
    rst = 1'b1;
    is_leader = 1'b0;
    hs_start = 1'b0;
    retry_cycles = 16'h12C;
    probe_need = 4'h1;
    ping_irq_en = 1'b1;
    wd_ping_en = 1'b0;
    wd_frame_en = 1'b0;
    tx_two_lanes = 1'b0;
    tx_words = 2'h0;
    tx_valid = 1'b0;
    tx_tag = 4'h0;
    tx_data = 64'h0;
    rx_two_lanes = 1'b0;
    rx_words = 2'h0;
    rx_skew = '0;
    p_two = 1'b0;
    p_words = 2'h0;
    leader_run();
    follower_run();
    results();
  end
endmodule : dclh_port_tb
